// file: shared/sdcps_pkg.sv
// sdcps_pkg: shared constants and types for the clock-enable power state control pair
// assumes: included before the interface and both end modules
package sdcps_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  // row cycle time, printed figure unknown here: plain default in ns
  localparam int unsigned ROW_CYCLE_TIME_NS = 70;
  localparam int unsigned ROW_CYCLE_CYC_RAW = (ROW_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ROW_CYCLE_CYC = (ROW_CYCLE_CYC_RAW < 1) ? 1 : ROW_CYCLE_CYC_RAW;
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] ROW_CYCLE_CNT = CNT_W'(ROW_CYCLE_CYC);
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 12'h000;

  // command encoding {cs_n, ras_n, cas_n, we_n}
  typedef logic [3:0] sdcps_cmd_t;
  localparam sdcps_cmd_t CMD_DESL = 4'hf;
  localparam sdcps_cmd_t CMD_NOP = 4'h7;
  localparam sdcps_cmd_t CMD_ACT = 4'h3;
  localparam sdcps_cmd_t CMD_PRE = 4'h2;
  localparam sdcps_cmd_t CMD_REF = 4'h1;
  localparam sdcps_cmd_t CMD_MRS = 4'h0;
  localparam sdcps_cmd_t CMD_READ = 4'h5;

  // device-level state as seen from clock enable
  typedef enum logic [2:0] {
    SDCPS_IDLE,
    SDCPS_ACTIVE,
    SDCPS_SELF_REFRESH,
    SDCPS_SREF_RECOVERY,
    SDCPS_POWER_DOWN,
    SDCPS_CLOCK_SUSPEND
  } sdcps_state_e;

  // controller requests
  typedef enum logic [2:0] {
    SDCPS_REQ_NONE,
    SDCPS_REQ_SELF_REFRESH,
    SDCPS_REQ_POWER_DOWN,
    SDCPS_REQ_SUSPEND,
    SDCPS_REQ_WAKE,
    SDCPS_REQ_COMMAND
  } sdcps_req_e;
endpackage

// file: shared/sdcps_if.sv
// sdcps_if: pins between memory controller and memory device
// assumes: one shared system clock drives both ends
`timescale 1ns/1ps
`default_nettype none
interface sdcps_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [11:0] addr;
  modport ctrl (output cke, output cs_n, output ras_n, output cas_n, output we_n, output addr);
  modport mem (input cke, input cs_n, input ras_n, input cas_n, input we_n, input addr);
endinterface
`default_nettype wire

// file: hw/sdcps_device.sv
// sdcps_device: clock-enable driven state tracking of the memory device end
// assumes: pins come through sdcps_if.mem, synchronous to sys_clk_i
// What this block and sdcps_ctrl do
// [R1] recovery plus deselect/nop reaches idle after row_cycle_time
// [R2] recovery, cke falls on nop: power-down next
// [R3] power-down ends on cke rise, to idle
// [R4] controller enters low power only with banks idle
// [R5] idle decode: activate/precharge, auto-refresh, mode set
// [R6] active state cke fall: clock suspend next cycle
// [R7] cke rise in suspend resumes suspended operation
// [R8] cke rise reactivates inputs; controller meets setup
// [R9] cke high twice in active: normal decode
// [R10] controller presents defined command entering suspend
// [R11] self-refresh ignores everything except clock enable and the deselect/nop check on its rise
// [R12] sample cke each edge, keep previous value
`timescale 1ns/1ps
`default_nettype none
module sdcps_device
  import sdcps_pkg::*;
(
  input wire logic sys_clk_i, // system clock
  input wire logic nrst_i, // async reset, active low
  sdcps_if.mem pins, // command pins from controller
  output sdcps_pkg::sdcps_state_e state_o, // current device state
  output logic illegal_o, // illegal command seen, one-cycle pulse
  output logic act_pre_o, // activate/precharge decoded, pulse
  output logic auto_refresh_o, // auto-refresh decoded, pulse
  output logic mode_set_o, // mode register set decoded, pulse
  output logic [11:0] mode_op_o, // last mode op code
  output logic active_cmd_o, // command decoded in active state, pulse
  output sdcps_pkg::sdcps_cmd_t active_cmd_code_o // that command's code
);
  import sdcps_pkg::*;

  sdcps_state_e state;
  sdcps_state_e next_state;
  sdcps_state_e resume_state;
  logic cke_prev;
  logic [CNT_W-1:0] rc_cnt;
  sdcps_cmd_t cmd;
  logic nop_like;

  assign cmd = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
  // cs high, or ras and cas high, counts as deselect/nop-type
  assign nop_like = pins.cs_n | (pins.ras_n & pins.cas_n);
  assign state_o = state;

  // previous-cycle clock enable, the n-1 column of every transition
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cke_prev <= 1'b1;
    end else begin
      cke_prev <= pins.cke; // [R12]
    end
  end

  // next state from previous and current cke plus command pins
  always_comb begin
    next_state = state;
    unique case (state)
      SDCPS_IDLE: begin
        if (cke_prev && !pins.cke && cmd == CMD_REF) begin
          next_state = SDCPS_SELF_REFRESH; // [R4]
        end else if (!cke_prev || (cke_prev && !pins.cke)) begin
          // a falling cke with deselect/nop, or cke already low, means power-down;
          // other commands with a falling cke leave the state idle and are not decoded
          if (!cke_prev || nop_like) begin
            next_state = SDCPS_POWER_DOWN; // [R4]
          end
        end else if (cmd == CMD_ACT) begin
          next_state = SDCPS_ACTIVE; // [R5]
        end
      end
      SDCPS_SELF_REFRESH: begin
        // only cke matters here; pins beyond the wake check are ignored
        if (!cke_prev && pins.cke && nop_like) begin
          next_state = SDCPS_SREF_RECOVERY; // [R11]
        end
      end
      SDCPS_SREF_RECOVERY: begin
        if (cke_prev && !pins.cke && nop_like) begin
          next_state = SDCPS_POWER_DOWN; // [R2]
        end else if (cke_prev && pins.cke && nop_like && rc_cnt == CNT_ZERO) begin
          next_state = SDCPS_IDLE; // [R1]
        end
      end
      SDCPS_POWER_DOWN: begin
        if (!cke_prev && pins.cke) begin
          next_state = SDCPS_IDLE; // [R3] [R8]
        end
      end
      SDCPS_ACTIVE: begin
        if (cke_prev && !pins.cke) begin
          next_state = SDCPS_CLOCK_SUSPEND; // [R6]
        end else if (cke_prev && pins.cke && (cmd == CMD_PRE)) begin
          next_state = SDCPS_IDLE; // [R9]
        end
      end
      SDCPS_CLOCK_SUSPEND: begin
        if (!cke_prev && pins.cke) begin
          next_state = resume_state; // [R7] [R8]
        end
      end
      default: next_state = SDCPS_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= SDCPS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // remember what clock suspend froze so it can resume unchanged
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      resume_state <= SDCPS_ACTIVE;
    end else if (state == SDCPS_ACTIVE && next_state == SDCPS_CLOCK_SUSPEND) begin
      resume_state <= SDCPS_ACTIVE; // [R6]
    end
  end

  // row cycle timer, loaded on entry to self-refresh recovery
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rc_cnt <= CNT_ZERO;
    end else if (state != SDCPS_SREF_RECOVERY && next_state == SDCPS_SREF_RECOVERY) begin
      rc_cnt <= ROW_CYCLE_CNT - 8'h01; // [R1]
    end else if (state == SDCPS_SREF_RECOVERY && rc_cnt != CNT_ZERO) begin
      rc_cnt <= rc_cnt - 8'h01;
    end
  end

  // illegal command flag: recovery and self-refresh exit with bad codes
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      illegal_o <= 1'b0;
    end else begin
      illegal_o <= ((state == SDCPS_SREF_RECOVERY && cke_prev) ||
                    (state == SDCPS_SELF_REFRESH && !cke_prev && pins.cke)) &&
                   !nop_like; // [R1] [R2]
    end
  end

  // idle decode, cke high in both cycles
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      act_pre_o <= 1'b0;
      auto_refresh_o <= 1'b0;
      mode_set_o <= 1'b0;
      mode_op_o <= ADDR_ZERO;
    end else begin
      act_pre_o <= (state == SDCPS_IDLE) && cke_prev && pins.cke &&
                   !pins.cs_n && !pins.ras_n && pins.cas_n; // [R5]
      auto_refresh_o <= (state == SDCPS_IDLE) && cke_prev && pins.cke && cmd == CMD_REF;
      mode_set_o <= (state == SDCPS_IDLE) && cke_prev && pins.cke && cmd == CMD_MRS;
      if (state == SDCPS_IDLE && cke_prev && pins.cke && cmd == CMD_MRS) begin
        mode_op_o <= pins.addr; // [R5]
      end
    end
  end

  // active-state command pass-through for the per-bank logic
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      active_cmd_o <= 1'b0;
      active_cmd_code_o <= CMD_DESL;
    end else begin
      active_cmd_o <= (state == SDCPS_ACTIVE) && cke_prev && pins.cke && !pins.cs_n; // [R9]
      if (state == SDCPS_ACTIVE && cke_prev && pins.cke) begin
        active_cmd_code_o <= cmd;
      end
    end
  end
endmodule
`default_nettype wire

// file: hw/sdcps_ctrl.sv
// sdcps_ctrl: controller end that drives clock enable and command pins
// assumes: user requests are synchronous to sys_clk_i; one request at a time
`timescale 1ns/1ps
`default_nettype none
module sdcps_ctrl
  import sdcps_pkg::*;
(
  input wire logic sys_clk_i, // system clock
  input wire logic nrst_i, // async reset, active low
  input wire sdcps_pkg::sdcps_req_e req_i, // user request
  input wire logic req_valid_i, // request strobe
  input wire sdcps_pkg::sdcps_cmd_t cmd_i, // command for command requests
  input wire logic [11:0] addr_i, // address for command requests
  input wire logic banks_idle_i, // user says both banks idle
  output logic req_ready_o, // request may be taken
  output logic refused_o, // request refused, pulse
  sdcps_if.ctrl pins // pins to device
);
  import sdcps_pkg::*;

  logic cke;
  sdcps_cmd_t cmd;
  logic [11:0] addr;
  logic low_power;

  assign pins.cke = cke;
  assign pins.cs_n = cmd[3];
  assign pins.ras_n = cmd[2];
  assign pins.cas_n = cmd[1];
  assign pins.we_n = cmd[0];
  assign pins.addr = addr;
  assign req_ready_o = 1'b1;

  // drive pins from requests; default back to nop each cycle
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cke <= 1'b1;
      cmd <= CMD_NOP;
      addr <= ADDR_ZERO;
      low_power <= 1'b0;
      refused_o <= 1'b0;
    end else begin
      cmd <= CMD_NOP; // [R10] defined code whenever cke drops
      addr <= ADDR_ZERO;
      refused_o <= 1'b0;
      if (req_valid_i) begin
        unique case (req_i)
          SDCPS_REQ_SELF_REFRESH: begin
            if (banks_idle_i && !low_power) begin
              cke <= 1'b0;
              cmd <= CMD_REF; // [R4]
              low_power <= 1'b1;
            end else begin
              refused_o <= 1'b1;
            end
          end
          SDCPS_REQ_POWER_DOWN: begin
            if (banks_idle_i && !low_power) begin
              cke <= 1'b0; // [R4]
              low_power <= 1'b1;
            end else begin
              refused_o <= 1'b1;
            end
          end
          SDCPS_REQ_SUSPEND: begin
            cke <= 1'b0; // [R10]
          end
          SDCPS_REQ_WAKE: begin
            cke <= 1'b1; // [R8] nop on the rising edge cycle only
            low_power <= 1'b0;
          end
          SDCPS_REQ_COMMAND: begin
            if (cke) begin
              cmd <= cmd_i;
              addr <= addr_i;
            end else begin
              refused_o <= 1'b1; // [R1] no command until awake
            end
          end
          default: ;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/sdcps_sva.sv
// sdcps_sva: timing relations between the shared pins and the device state
// assumes: instantiated once beside sdcps_if in the bench top; one clock domain
`timescale 1ns/1ps
`default_nettype none
module sdcps_sva
  import sdcps_pkg::*;
(
  input wire logic sys_clk_i, // system clock
  input wire logic nrst_i, // async reset, active low
  input wire logic cke, // clock enable pin
  input wire logic cs_n, // chip select pin
  input wire logic ras_n, // row strobe pin
  input wire logic cas_n, // column strobe pin
  input wire logic we_n, // write enable pin
  input wire sdcps_pkg::sdcps_state_e state_o, // device state
  input wire logic auto_refresh_o, // auto-refresh pulse
  input wire logic mode_set_o // mode set pulse
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // deselect or nop: the only codes legal around a recovery
  wire sdcps_cmd_t cmd = {cs_n, ras_n, cas_n, we_n};
  wire logic nop_like = cs_n | (ras_n & cas_n);

  // entries and exits are judged from the previous and present enable level; suspend exit from the present level only, recovery end by a cycle bound
  a_sref_entry: assert property (state_o == SDCPS_IDLE && $past(cke) && !cke && cmd == CMD_REF
    |=> state_o == SDCPS_SELF_REFRESH) else $error("self-refresh not entered");
  a_sref_hold: assert property (state_o == SDCPS_SELF_REFRESH && !cke
    |=> state_o == SDCPS_SELF_REFRESH) else $error("self-refresh left early");
  a_sref_exit: assert property (state_o == SDCPS_SELF_REFRESH && cke && !$past(cke) && nop_like
    |=> state_o == SDCPS_SREF_RECOVERY) else $error("no recovery after wake");
  a_recovery_ends: assert property ($rose(state_o == SDCPS_SREF_RECOVERY)
    |-> ##[1:8] state_o != SDCPS_SREF_RECOVERY) else $error("recovery never ends");
  a_recovery_pdown: assert property (state_o == SDCPS_SREF_RECOVERY && $past(cke) && !cke
    && nop_like |=> state_o == SDCPS_POWER_DOWN) else $error("no power-down");
  a_pdown_exit: assert property (state_o == SDCPS_POWER_DOWN && cke && !$past(cke)
    |=> state_o == SDCPS_IDLE) else $error("power-down not ended");
  a_suspend_entry: assert property (state_o == SDCPS_ACTIVE && $past(cke) && !cke
    |=> state_o == SDCPS_CLOCK_SUSPEND) else $error("suspend not entered");
  a_suspend_exit: assert property (state_o == SDCPS_CLOCK_SUSPEND && cke
    |=> state_o == SDCPS_ACTIVE) else $error("suspend not ended");
  a_idle_refresh: assert property (state_o == SDCPS_IDLE && cke && $past(cke) && cmd == CMD_REF
    |=> auto_refresh_o) else $error("auto-refresh not decoded");
  a_idle_mode_set: assert property (state_o == SDCPS_IDLE && cke && $past(cke)
    && cmd == CMD_MRS |=> mode_set_o) else $error("mode set not decoded");
endmodule
`default_nettype wire

// file: bench/test_sdcps.sv
// test_sdcps: drives the controller user side and judges the device outputs
// assumes: sdcps_ctrl and sdcps_device face each other through sdcps_if
`timescale 1ns/1ps
`default_nettype none
module test_sdcps;
  import sdcps_pkg::*;
  logic sys_clk_i, nrst_i, req_valid_i, banks_idle_i, refused_o;
  logic illegal_o;
  logic auto_refresh_o, mode_set_o, active_cmd_o, act_pre_o;
  logic [11:0] addr_i, mode_op_o;
  sdcps_req_e req_i;
  sdcps_cmd_t cmd_i, active_cmd_code_o;
  sdcps_state_e state_o;
  int miscompares = 0;
  int checks = 0;

  sdcps_if bus ();
  sdcps_ctrl i_sdcps_ctrl (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .req_i(req_i),
    .req_valid_i(req_valid_i), .cmd_i(cmd_i), .addr_i(addr_i), .banks_idle_i(banks_idle_i),
    .req_ready_o(), .refused_o(refused_o), .pins(bus.ctrl));
  sdcps_device i_sdcps_device (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .pins(bus.mem),
    .state_o(state_o), .illegal_o(illegal_o), .act_pre_o(act_pre_o),
    .auto_refresh_o(auto_refresh_o),
    .mode_set_o(mode_set_o), .mode_op_o(mode_op_o), .active_cmd_o(active_cmd_o),
    .active_cmd_code_o(active_cmd_code_o));
  sdcps_sva i_sdcps_sva (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .cke(bus.cke),
    .cs_n(bus.cs_n), .ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n),
    .state_o(state_o), .auto_refresh_o(auto_refresh_o), .mode_set_o(mode_set_o));

  // shared helpers; every caller leaves a negedge between two strobes
  task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic send(input sdcps_req_e r, input sdcps_cmd_t c, input logic [11:0] a);
    req_i = r;
    cmd_i = c;
    addr_i = a;
    req_valid_i = 1'b1;
    step(1);
    req_valid_i = 1'b0;
  endtask

  // idle decode; device answers one edge after the pins change
  task automatic t_idle_decode;
    send(SDCPS_REQ_COMMAND, CMD_REF, 12'h000);
    step(1);
    chk("auto_refresh", 12'(auto_refresh_o), 12'h001);
    send(SDCPS_REQ_COMMAND, CMD_MRS, 12'h0a5);
    step(3);
    chk("mode_op", mode_op_o, 12'h0a5);
    send(SDCPS_REQ_COMMAND, CMD_ACT, 12'h001);
    step(1);
    chk("act_pre", 12'(act_pre_o), 12'h001);
    chk("state", 12'(state_o), 12'(SDCPS_ACTIVE));
  endtask

  // suspend holds while enable is low, then resumes the open row
  task automatic t_suspend;
    send(SDCPS_REQ_SUSPEND, CMD_NOP, 12'h000);
    step(3);
    chk("state", 12'(state_o), 12'(SDCPS_CLOCK_SUSPEND));
    send(SDCPS_REQ_WAKE, CMD_NOP, 12'h000);
    step(1);
    chk("state", 12'(state_o), 12'(SDCPS_ACTIVE));
    send(SDCPS_REQ_COMMAND, CMD_READ, 12'h010);
    step(1);
    chk("active_cmd_code", 12'(active_cmd_code_o), 12'(CMD_READ));
    chk("active_cmd", 12'(active_cmd_o), 12'h001);
    send(SDCPS_REQ_COMMAND, CMD_PRE, 12'h000);
    step(2);
    chk("state", 12'(state_o), 12'(SDCPS_IDLE));
  endtask

  // refusal with busy banks, then self-refresh and a full recovery
  task automatic t_sref_recovery;
    int n;
    n = 0;
    banks_idle_i = 1'b0;
    send(SDCPS_REQ_SELF_REFRESH, CMD_NOP, 12'h000);
    chk("refused", 12'(refused_o), 12'h001);
    banks_idle_i = 1'b1;
    step(1);
    send(SDCPS_REQ_SELF_REFRESH, CMD_NOP, 12'h000);
    step(4);
    chk("state", 12'(state_o), 12'(SDCPS_SELF_REFRESH));
    send(SDCPS_REQ_WAKE, CMD_NOP, 12'h000);
    step(1);
    chk("state", 12'(state_o), 12'(SDCPS_SREF_RECOVERY));
    while (state_o !== SDCPS_IDLE && n < ROW_CYCLE_CYC + 2) begin
      step(1);
      n++;
    end
    chk("recovery_cycles", 12'(n), 12'(ROW_CYCLE_CYC));
    chk("state", 12'(state_o), 12'(SDCPS_IDLE));
    step(1);
  endtask

  // enable dropped during recovery leads to power-down, a rise ends it
  task automatic t_power_down;
    send(SDCPS_REQ_SELF_REFRESH, CMD_NOP, 12'h000);
    step(2);
    send(SDCPS_REQ_WAKE, CMD_NOP, 12'h000);
    step(1);
    // an activate during recovery is flagged, and recovery carries on
    send(SDCPS_REQ_COMMAND, CMD_ACT, 12'h001);
    step(1);
    chk("illegal", 12'(illegal_o), 12'h001);
    chk("state", 12'(state_o), 12'(SDCPS_SREF_RECOVERY));
    send(SDCPS_REQ_POWER_DOWN, CMD_NOP, 12'h000);
    step(3);
    chk("state", 12'(state_o), 12'(SDCPS_POWER_DOWN));
    send(SDCPS_REQ_WAKE, CMD_NOP, 12'h000);
    step(1);
    chk("state", 12'(state_o), 12'(SDCPS_IDLE));
  endtask

  task automatic summarize;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  // inputs move on the falling edge so the rising edge samples settled values
  initial begin
    nrst_i = 1'b0;
    req_i = SDCPS_REQ_NONE;
    req_valid_i = 1'b0;
    cmd_i = CMD_NOP;
    addr_i = 12'h000;
    banks_idle_i = 1'b1;
    step(3);
    nrst_i = 1'b1;
    step(1);
    t_idle_decode;
    t_suspend;
    t_sref_recovery;
    t_power_down;
    summarize;
  end
  // the whole run needs about fifty cycles; forty times that means a hang
  initial begin
    repeat (2000) @(posedge sys_clk_i);
    miscompares++;
    summarize;
  end
endmodule
`default_nettype wire
